// [hw/sign_skip_pkg.sv]
// Purpose: Shared types and constants for the sign and skip executor
// Assumes: One core clock, synchronous active-high reset
// Notes: Opcode byte layout is local to this core
`default_nettype none
package sign_skip_pkg;
	localparam int ACC_W = 24;
	localparam int PC_W = 16;
	localparam int BYTE_W = 8;
	localparam int BIT_POS_W = 5;
	localparam int COUNT_W = 2;
	localparam logic [ACC_W-1:0] SIGN_PLUS = 24'h000001;
	localparam logic [ACC_W-1:0] SIGN_MINUS = 24'hffffff;
	localparam logic [PC_W-1:0] SIGN_BYTES = 16'h0002;
	localparam logic [PC_W-1:0] SKIP_BYTES = 16'h0001;
	// Length field of any opcode byte: bits 7..6 hold length minus one
	localparam int LEN_FIELD_LSB = 6;
	localparam int LEN_FIELD_W = 2;
	localparam logic [PC_W-1:0] RESET_PC = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 2'h0;

	typedef enum logic [2:0] {
		OP_SIGN = 3'h0,
		OP_SKIP = 3'h1,
		OP_SKIP_IF_BIT_CLEAR = 3'h2,
		OP_SKIP_IF_BIT_SET = 3'h3,
		OP_SKIP_IF_CARRY_CLEAR = 3'h4,
		OP_SKIP_IF_CARRY_SET = 3'h5,
		OP_SKIP_IF_ZERO_RESULT = 3'h6,
		OP_SKIP_IF_NONZERO_RESULT = 3'h7
	} op_e;

	typedef enum logic [1:0] {
		ACC_X = 2'h0,
		ACC_Y = 2'h1,
		ACC_Z = 2'h2,
		ACC_R = 2'h3
	} acc_sel_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SIGN = 3'h1,
		ST_WAIT = 3'h2,
		ST_LEN = 3'h3
	} state_e;

	typedef struct packed {
		op_e op;
		acc_sel_e accumulator_select;
		logic [BIT_POS_W-1:0] bit_pos;
		logic [COUNT_W-1:0] count;
		logic [PC_W-1:0] pc;
	} instr_s;

	typedef struct packed {
		logic carry;
		logic overflow;
		logic sign;
		logic nonzero;
	} flags_s;

	typedef logic [3:0][ACC_W-1:0] acc_bank_t;

	typedef struct packed {
		logic we;
		acc_sel_e sel;
		logic [ACC_W-1:0] data;
	} acc_write_s;

	typedef struct packed {
		logic we;
		logic sign;
		logic nonzero;
	} flag_write_s;
endpackage
`default_nettype wire

// [hw/instr_length.sv]
// Purpose: Byte length of an instruction from its first byte
// Assumes: Length field sits in the top bits of every opcode byte
// Notes: Purely combinational
`default_nettype none
module instr_length (
	input wire logic [sign_skip_pkg::BYTE_W-1:0] first_byte_in,
	output logic [sign_skip_pkg::PC_W-1:0] length_out
);
	logic [sign_skip_pkg::LEN_FIELD_W-1:0] field;

	always_comb begin
		field = first_byte_in[sign_skip_pkg::LEN_FIELD_LSB +: sign_skip_pkg::LEN_FIELD_W];
		length_out = sign_skip_pkg::PC_W'({14'h0000, field}) + 16'h0001;
	end
endmodule // instr_length
`default_nettype wire

// [hw/sign_unit.sv]
// Purpose: Registered two's-complement sign of a 24-bit operand
// Assumes: load_in is a one-cycle pulse
// Notes: Result holds until the next load
`default_nettype none
module sign_unit (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic [sign_skip_pkg::ACC_W-1:0] operand_in,
	output logic [sign_skip_pkg::ACC_W-1:0] result_out,
	output logic negative_out
);
	logic [sign_skip_pkg::ACC_W-1:0] next_result;
	logic next_negative;

	always_comb begin
		next_result = result_out;
		next_negative = negative_out;
		if (load_in) begin
			next_negative = operand_in[sign_skip_pkg::ACC_W-1];
			next_result = next_negative ? sign_skip_pkg::SIGN_MINUS : sign_skip_pkg::SIGN_PLUS;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			result_out <= sign_skip_pkg::SIGN_PLUS;
			negative_out <= 1'b0;
		end else begin
			result_out <= next_result;
			negative_out <= next_negative;
		end
	end
endmodule // sign_unit
`default_nettype wire

// [hw/sign_skip_exec.sv]
// Purpose: Executes the sign instruction and the skip family
// Assumes: Program memory answers one cycle after a read strobe
// Notes: Issue while busy is ignored
// What this block does
// - Sign writes 0x000001 for non-negative accumulator, 0xFFFFFF for negative.
// - A zero operand counts as positive, giving plus one.
// - Sign is two's complement, any accumulator, 2 bytes, 2 cycles, flags S and Z.
// - Plain skip advances PC over the next 1 to 3 instructions, per count; a count of zero skips none.
// - Skips are one byte, take one cycle plus two per skipped instruction, keep flags.
// - Bit-clear skip skips when selected accumulator bit is zero.
// - Bit-set skip skips when selected accumulator bit is one.
// - Carry-clear skip skips only when carry is zero.
// - Carry-set skip skips only when carry is one.
// - Zero skip skips when the non-zero flag is zero.
// - Non-zero skip skips when the non-zero flag is one.
`default_nettype none
module sign_skip_exec (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic issue_in,
	input wire sign_skip_pkg::instr_s instr_in,
	input wire sign_skip_pkg::acc_bank_t acc_in,
	input wire sign_skip_pkg::flags_s flags_in,
	input wire logic [sign_skip_pkg::BYTE_W-1:0] mem_data_in,
	output logic busy_out,
	output logic done_out,
	output logic [sign_skip_pkg::PC_W-1:0] next_pc_out,
	output logic mem_rd_out,
	output logic [sign_skip_pkg::PC_W-1:0] mem_addr_out,
	output sign_skip_pkg::acc_write_s acc_write_out,
	output sign_skip_pkg::flag_write_s flag_write_out
);
	sign_skip_pkg::state_e state;
	sign_skip_pkg::state_e next_state;
	sign_skip_pkg::instr_s held;
	sign_skip_pkg::instr_s next_held;
	logic [sign_skip_pkg::COUNT_W-1:0] remaining;
	logic [sign_skip_pkg::COUNT_W-1:0] next_remaining;
	logic next_done;
	logic [sign_skip_pkg::PC_W-1:0] next_next_pc;
	logic next_mem_rd;
	logic [sign_skip_pkg::PC_W-1:0] next_mem_addr;
	sign_skip_pkg::acc_write_s next_acc_write;
	sign_skip_pkg::flag_write_s next_flag_write;

	logic accept;
	logic sign_load;
	logic [sign_skip_pkg::ACC_W-1:0] operand;
	logic [sign_skip_pkg::ACC_W-1:0] sign_result;
	logic sign_negative;
	logic selected_bit;
	logic skip_taken;
	logic [sign_skip_pkg::PC_W-1:0] skipped_len;
	logic bit_in_range;
	logic [3:0] acc_bit;

	assign busy_out = (state != sign_skip_pkg::ST_IDLE);
	assign accept = issue_in && (state == sign_skip_pkg::ST_IDLE);

	// Positions past the top bit read as zero, never unknown
	assign bit_in_range = (instr_in.bit_pos < sign_skip_pkg::BIT_POS_W'(sign_skip_pkg::ACC_W));

	// Selected bit of every accumulator
	for (genvar g = 0; g < 4; g++) begin : g_acc
		assign acc_bit[g] = bit_in_range && acc_in[g][instr_in.bit_pos];
	end

	// Operand and bit pick from the addressed accumulator
	always_comb begin
		operand = acc_in[instr_in.accumulator_select];
		selected_bit = acc_bit[instr_in.accumulator_select];
		sign_load = accept && (instr_in.op == sign_skip_pkg::OP_SIGN);
	end

	sign_unit u_sign (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.load_in(sign_load),
		.operand_in(operand),
		.result_out(sign_result),
		.negative_out(sign_negative)
	);

	instr_length u_len (
		.first_byte_in(mem_data_in),
		.length_out(skipped_len)
	);

	// Skip condition per opcode
	always_comb begin
		skip_taken = 1'b0;
		unique case (instr_in.op)
			sign_skip_pkg::OP_SIGN: begin
				skip_taken = 1'b0;
			end
			sign_skip_pkg::OP_SKIP: begin
				skip_taken = 1'b1;
			end
			sign_skip_pkg::OP_SKIP_IF_BIT_CLEAR: begin
				skip_taken = !selected_bit;
			end
			sign_skip_pkg::OP_SKIP_IF_BIT_SET: begin
				skip_taken = selected_bit;
			end
			sign_skip_pkg::OP_SKIP_IF_CARRY_CLEAR: begin
				skip_taken = !flags_in.carry;
			end
			sign_skip_pkg::OP_SKIP_IF_CARRY_SET: begin
				skip_taken = flags_in.carry;
			end
			sign_skip_pkg::OP_SKIP_IF_ZERO_RESULT: begin
				skip_taken = !flags_in.nonzero;
			end
			sign_skip_pkg::OP_SKIP_IF_NONZERO_RESULT: begin
				skip_taken = flags_in.nonzero;
			end
		endcase
		// Count of zero would skip nothing
		if (instr_in.count == sign_skip_pkg::COUNT_RESET) begin
			skip_taken = 1'b0;
		end
	end

	// Sequencer next state and outputs
	always_comb begin
		next_state = state;
		next_held = held;
		next_remaining = remaining;
		next_done = 1'b0;
		next_next_pc = next_pc_out;
		next_mem_rd = 1'b0;
		next_mem_addr = mem_addr_out;
		next_acc_write = acc_write_out;
		next_acc_write.we = 1'b0;
		next_flag_write = flag_write_out;
		next_flag_write.we = 1'b0;
		unique case (state)
			sign_skip_pkg::ST_IDLE: begin
				if (accept) begin
					next_held = instr_in;
					if (instr_in.op == sign_skip_pkg::OP_SIGN) begin
						next_state = sign_skip_pkg::ST_SIGN;
					end else if (skip_taken) begin
						next_remaining = instr_in.count;
						next_mem_rd = 1'b1;
						next_mem_addr = instr_in.pc + sign_skip_pkg::SKIP_BYTES;
						next_state = sign_skip_pkg::ST_WAIT;
					end else begin
						// one byte, one cycle, flags kept
						next_done = 1'b1;
						next_next_pc = instr_in.pc + sign_skip_pkg::SKIP_BYTES;
					end
				end
			end
			sign_skip_pkg::ST_SIGN: begin
				// two bytes, sign and zero flags only
				next_acc_write.we = 1'b1;
				next_acc_write.sel = held.accumulator_select;
				next_acc_write.data = sign_result;
				next_flag_write.we = 1'b1;
				next_flag_write.sign = sign_negative;
				next_flag_write.nonzero = 1'b1;
				next_done = 1'b1;
				next_next_pc = held.pc + sign_skip_pkg::SIGN_BYTES;
				next_state = sign_skip_pkg::ST_IDLE;
			end
			sign_skip_pkg::ST_WAIT: begin
				next_state = sign_skip_pkg::ST_LEN;
			end
			sign_skip_pkg::ST_LEN: begin
				next_mem_addr = mem_addr_out + skipped_len;
				next_remaining = remaining - 2'h1;
				if (remaining == 2'h1) begin
					next_done = 1'b1;
					next_next_pc = mem_addr_out + skipped_len;
					next_state = sign_skip_pkg::ST_IDLE;
				end else begin
					next_mem_rd = 1'b1;
					next_state = sign_skip_pkg::ST_WAIT;
				end
			end
			default: begin
				next_state = sign_skip_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= sign_skip_pkg::ST_IDLE;
			held <= '0;
			remaining <= sign_skip_pkg::COUNT_RESET;
			done_out <= 1'b0;
			next_pc_out <= sign_skip_pkg::RESET_PC;
			mem_rd_out <= 1'b0;
			mem_addr_out <= sign_skip_pkg::RESET_PC;
			acc_write_out <= '0;
			flag_write_out <= '0;
		end else begin
			state <= next_state;
			held <= next_held;
			remaining <= next_remaining;
			done_out <= next_done;
			next_pc_out <= next_next_pc;
			mem_rd_out <= next_mem_rd;
			mem_addr_out <= next_mem_addr;
			acc_write_out <= next_acc_write;
			flag_write_out <= next_flag_write;
		end
	end
endmodule // sign_skip_exec
`default_nettype wire

// [bench/sign_skip_exec_monitor.sv]
// Purpose: Port checker for the sign and skip executor
// Assumes: Single clock, synchronous reset
// Notes: Bound to the design below
`default_nettype none
module sign_skip_monitor (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic issue_in,
	input wire sign_skip_pkg::instr_s instr_in,
	input wire sign_skip_pkg::acc_bank_t acc_in,
	input wire sign_skip_pkg::flags_s flags_in,
	input wire logic [sign_skip_pkg::BYTE_W-1:0] mem_data_in,
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic [sign_skip_pkg::PC_W-1:0] next_pc_out,
	input wire logic mem_rd_out,
	input wire logic [sign_skip_pkg::PC_W-1:0] mem_addr_out,
	input wire sign_skip_pkg::acc_write_s acc_write_out,
	input wire sign_skip_pkg::flag_write_s flag_write_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic take, is_sign, neg, bitv, cond, go;
	logic [7:0] cond_vec;
	assign take = issue_in && !busy_out;
	assign is_sign = instr_in.op == sign_skip_pkg::OP_SIGN;
	assign neg = acc_in[instr_in.accumulator_select][23];
	assign bitv = acc_in[instr_in.accumulator_select][instr_in.bit_pos];
	// Skip condition indexed by opcode
	assign cond_vec = {flags_in.nonzero, !flags_in.nonzero, flags_in.carry, !flags_in.carry, bitv, !bitv, 2'b10};
	assign cond = cond_vec[instr_in.op];
	assign go = take && !is_sign && cond && instr_in.count != 2'h0;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_sign_value: assert property (take && is_sign |-> ##2 done_out && acc_write_out.we &&
		acc_write_out.data == ($past(neg, 2) ? 24'hffffff : 24'h000001)) else $error("sign result wrong");
	a_sign_flags: assert property (take && is_sign |-> ##2 flag_write_out.we &&
		flag_write_out.sign == $past(neg, 2) && flag_write_out.nonzero) else $error("sign flags wrong");
	a_sign_pc: assert property (take && is_sign |-> ##2 next_pc_out == $past(instr_in.pc, 2) + 16'h0002)
		else $error("sign pc wrong");
	a_sign_busy: assert property (take && is_sign |=> busy_out && !done_out)
		else $error("sign finished early");
	a_skip_fall: assert property (take && !is_sign && !go |=> done_out &&
		next_pc_out == $past(instr_in.pc) + 16'h0001) else $error("fall through wrong");
	a_skip_fetch: assert property (go |=> mem_rd_out && !done_out &&
		mem_addr_out == $past(instr_in.pc) + 16'h0001) else $error("skip fetch wrong");
	a_skip_one: assert property (go && instr_in.count == 2'h1 |-> ##3 done_out &&
		next_pc_out == $past(instr_in.pc, 3) + 16'h0002 + $past(mem_data_in[7:6])) else $error("skip one wrong");
	a_flags_kept: assert property (flag_write_out.we |-> acc_write_out.we && done_out)
		else $error("flags written by skip");
	cover property (take && is_sign && neg);
	cover property (go && instr_in.count == 2'h3);
	cover property (issue_in && busy_out);
endmodule // sign_skip_monitor
bind sign_skip_exec sign_skip_monitor u_mon (.clk_in, .rst_in, .issue_in, .instr_in, .acc_in, .flags_in,
	.mem_data_in, .busy_out, .done_out, .next_pc_out, .mem_rd_out, .mem_addr_out, .acc_write_out, .flag_write_out);
`default_nettype wire

// [bench/test_sign_skip_exec.sv]
// Purpose: Directed bench for the sign and skip executor
// Assumes: Program memory modelled by a byte array
// Notes: Inputs change on falling edges
`default_nettype none
module test_sign_skip_exec;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in, rst_in, issue_in, busy_out, done_out, mem_rd_out;
	sign_skip_pkg::instr_s instr_in;
	sign_skip_pkg::acc_bank_t acc_in;
	sign_skip_pkg::flags_s flags_in;
	logic [7:0] mem_data_in;
	logic [15:0] next_pc_out, mem_addr_out;
	sign_skip_pkg::acc_write_s acc_write_out;
	sign_skip_pkg::flag_write_s flag_write_out;
	logic [7:0] prog [256];
	logic [15:0] lens [4];
	logic [23:0] vals [4];
	int err_total, comparisons;
	sign_skip_exec u_dut (.clk_in, .rst_in, .issue_in, .instr_in, .acc_in, .flags_in, .mem_data_in,
		.busy_out, .done_out, .next_pc_out, .mem_rd_out, .mem_addr_out, .acc_write_out, .flag_write_out);
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// Program memory, one cycle latency
	always @(negedge clk_in) begin
		if (rst_in === 1'b1) begin
			mem_data_in <= 8'h00;
		end else if (mem_rd_out === 1'b1) begin
			mem_data_in <= prog[mem_addr_out[7:0]];
		end
	end
	task automatic chk(bit ok, string m);
		comparisons++;
		if (!ok) begin
			err_total++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic run(logic [2:0] op, logic [1:0] sel, logic [4:0] bp, logic [1:0] cnt, output int cyc);
		@(negedge clk_in);
		instr_in = '{sign_skip_pkg::op_e'(op), sign_skip_pkg::acc_sel_e'(sel), bp, cnt, 16'h0040};
		issue_in = 1'b1;
		for (cyc = 1; cyc < 20; cyc++) begin
			@(negedge clk_in);
			if (done_out === 1'b1) break;
			// Re-issue while busy must be ignored
			issue_in = (cyc == 1 && cnt == 2'h3);
		end
		issue_in = 1'b0;
		if (cyc == 20) begin
			chk(1'b0, "no done");
			conclude();
		end
	endtask
	task automatic sign_case(logic [1:0] sel, logic [23:0] v);
		int cyc;
		acc_in = {4{~v}};
		acc_in[sel] = v;
		run(3'h0, sel, 5'h00, 2'h0, cyc);
		chk(cyc == 2 && acc_write_out.we === 1'b1 && next_pc_out === 16'h0042, "sign timing");
		chk(acc_write_out.data === (v[23] ? 24'hffffff : 24'h000001) && acc_write_out.sel === sel, "sign value");
		chk(flag_write_out === {1'b1, v[23], 1'b1}, "sign flags");
	endtask
	task automatic skip_case(logic [2:0] op, bit want, logic [1:0] cnt);
		logic b;
		logic [4:0] bp;
		logic [23:0] m;
		int cyc;
		b = op[0] ? want : !want;
		bp = 5'(cnt * 7);
		m = 24'h000001 << bp;
		acc_in = {4{b ? ~m : m}};
		acc_in[2] = b ? m : ~m;
		flags_in = '{b, !b, !b, b};
		run(op, 2'h2, bp, cnt, cyc);
		chk(next_pc_out === 16'h0041 + (want ? lens[cnt] : 16'h0000), "skip pc");
		chk(cyc == (want ? 1 + 2 * cnt : 1), "skip cycles");
		chk(flag_write_out.we === 1'b0 && acc_write_out.we === 1'b0, "skip wrote state");
	endtask
	initial begin
		rst_in = 1'b1;
		issue_in = 1'b0;
		instr_in = '0;
		acc_in = '0;
		flags_in = '0;
		err_total = 0;
		comparisons = 0;
		prog = '{default: 8'h00};
		// Lengths 2, 3 (unused byte), 1, 4 after the skip
		prog[8'h41] = 8'h40;
		prog[8'h42] = 8'h80;
		prog[8'h44] = 8'hc0;
		lens = '{16'h0000, 16'h0002, 16'h0003, 16'h0007};
		vals = '{24'h000000, 24'h7fffff, 24'h800000, 24'hffffff};
		repeat (2) @(negedge clk_in);
		chk(busy_out === 1'b0 && done_out === 1'b0 && next_pc_out === 16'h0000, "reset state");
		rst_in = 1'b0;
		for (int i = 0; i < 4; i++) begin
			sign_case(2'(i), vals[i]);
		end
		for (int o = 1; o < 8; o++) begin
			for (int c = 1; c < 4; c++) begin
				skip_case(3'(o), 1'b1, 2'(c));
				if (o > 1) skip_case(3'(o), 1'b0, 2'(c));
			end
		end
		// Count of zero falls through
		skip_case(3'h1, 1'b0, 2'h0);
		conclude();
	end
endmodule // test_sign_skip_exec
`default_nettype wire
